// File: pkg/watchdog_defs.vh
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH

// register map (byte address on the slave bus)
`define WDG_ADDR_COUNT_CONTROL 8'hD8
`define WDG_ADDR_W             8

// field positions in watchdog_count_control
`define WDG_BIT_ACTIVATE       0
`define WDG_BIT_SOFT_RESET     1
`define WDG_BIT_COUNTER_LSB    7
`define WDG_BIT_PERIOD_MSB     2

// reset values
`define WDG_REG_RESET          8'hFE
`define WDG_CNT_RESET          7'h7F
`define WDG_CNT_ZERO           6'h00

// timing counts, in core clock cycles or instructions
`define WDG_TICK_CYCLES        3072
`define WDG_GUARD_INSTR        28
`define WDG_STAB_CYCLES        2048

// power states
`define WDG_ST_RUN             2'h0
`define WDG_ST_WAIT            2'h1
`define WDG_ST_STOP            2'h2

`endif

// File: design/level_sync.v
`timescale 1ns/100ps
`default_nettype none

module level_sync (
    // clock and reset
    input  wire clk_sys,
    input  wire sys_rst,
    // async level in, synchronised level out
    input  wire din,
    output wire dout
);

    reg meta_reg;
    reg sync_reg;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;

endmodule

`default_nettype wire

// File: design/reset_stretch.v
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_defs.vh"

module reset_stretch #(
    parameter HOLD_CYCLES = `WDG_STAB_CYCLES,
    parameter CNT_W       = 12
) (
    // clock and reset
    input  wire clk_sys,
    input  wire sys_rst,
    // one-cycle trigger in, held reset out
    input  wire trigger,
    output wire hold
);

    localparam integer     LAST_I = HOLD_CYCLES - 1;
    localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] ONE    = {{(CNT_W-1){1'b0}}, 1'b1};

    reg             hold_reg;
    reg [CNT_W-1:0] cnt_reg;

    // stretched like a pin reset so the restart sees the same settling delay
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            hold_reg <= 1'b0;
            cnt_reg  <= {CNT_W{1'b0}};
        end else if (trigger) begin
            hold_reg <= 1'b1;
            cnt_reg  <= {CNT_W{1'b0}};
        end else if (hold_reg) begin
            if (cnt_reg == LAST) begin
                hold_reg <= 1'b0;
            end
            cnt_reg <= cnt_reg + ONE;
        end
    end

    assign hold = hold_reg;

endmodule

`default_nettype wire

// File: design/watchdog_core.v
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_defs.vh"

// Notes on behaviour
// [RULE_01] active counter decrements, expiry resets device
// [RULE_02] reset when physical bit 6 falls
// [RULE_03] software option: inactive until activation written
// [RULE_04] activation sticks; only system reset clears; the code also clears it on a watchdog reset
// [RULE_05] hardware option: activation forced one always
// [RULE_06] hardware, no external control: stop becomes wait
// [RULE_07] inactive watchdog: stop is true stop
// [RULE_08] external control: pin high stops, low waits
// [RULE_09] wake from stop resumes held count
// [RULE_10] register resets to FE
// [RULE_11] clearing soft reset bit triggers reset
// [RULE_12] register counter bits stored reversed
// [RULE_13] inactive: free 7-bit timer incl. soft bit
// [RULE_14] 64 periods, 3072 to 196608 cycles
// [RULE_15] software checks activation in 27 instructions
// [RULE_16] external party keeps stop pin high normally
// [RULE_17] watchdog reset stretched like pin reset
// [RULE_18] 28 instructions after activation before reset
// [RULE_19] reset pin driven low during internal reset
// [RULE_20] write loads counter and soft bit at once
module watchdog_core #(
    parameter TICK_CYCLES = `WDG_TICK_CYCLES,
    parameter GUARD_INSTR = `WDG_GUARD_INSTR,
    parameter STAB_CYCLES = `WDG_STAB_CYCLES
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // avalon-mm slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // factory options and stop control pin
    input  wire        opt_hw_activation,
    input  wire        opt_ext_stop,
    input  wire        nmi_pin,
    // core events, same clock
    input  wire        stop_instr,
    input  wire        wake_irq,
    input  wire        instr_done,
    // power state and reset outputs
    output wire        stop_mode,
    output wire        wait_mode,
    output wire        watchdog_active,
    output wire        wdg_reset,
    output wire        reset_pin_o,
    output wire        reset_pin_oe
);

    localparam integer TICK_LAST_I = TICK_CYCLES - 1;
    localparam [11:0]  TICK_LAST   = TICK_LAST_I[11:0];
    localparam integer GUARD_N_I   = GUARD_INSTR;
    localparam [4:0]   GUARD_N     = GUARD_N_I[4:0];

    // physical counter -> register byte, bits reversed
    function [7:0] cnt_to_reg;
        input [6:0] cnt;
        input       act;
        integer     i;
        begin
            cnt_to_reg = 8'h00;
            for (i = 0; i < 6; i = i + 1) begin
                cnt_to_reg[`WDG_BIT_COUNTER_LSB - i] = cnt[i];
            end
            cnt_to_reg[`WDG_BIT_SOFT_RESET] = cnt[6];
            cnt_to_reg[`WDG_BIT_ACTIVATE]   = act;
        end
    endfunction

    // register byte -> physical counter
    function [6:0] reg_to_cnt;
        input [7:0] b;
        integer     i;
        begin
            reg_to_cnt = 7'h00;
            for (i = 0; i < 6; i = i + 1) begin
                reg_to_cnt[i] = b[`WDG_BIT_COUNTER_LSB - i];
            end
            reg_to_cnt[6] = b[`WDG_BIT_SOFT_RESET];
        end
    endfunction

    // synchronised pins
    wire hw_opt;
    wire ext_opt;
    wire nmi_level;

    level_sync sync_hw (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (opt_hw_activation),
        .dout    (hw_opt)
    );

    level_sync sync_ext (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (opt_ext_stop),
        .dout    (ext_opt)
    );

    level_sync sync_nmi (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .din     (nmi_pin),
        .dout    (nmi_level)
    );

    // state
    reg        act_reg;
    reg [6:0]  cnt_reg;
    reg [11:0] presc_reg;
    reg [1:0]  pwr_reg;
    reg [1:0]  pwr_next;
    reg        pending_reg;
    reg [4:0]  guard_reg;
    reg        active_d_reg;
    reg        ack_reg;
    reg [31:0] rdata_reg;
    reg        trig_reg;

    wire hold;
    wire int_rst;
    wire active;
    wire frozen;
    wire tick;
    wire req;
    wire hit;
    wire wr_hit;
    wire expire;
    wire guard_done;
    wire soft_clear;
    wire [7:0] reg_view;

    reset_stretch #(
        .HOLD_CYCLES (STAB_CYCLES),
        .CNT_W       (12)
    ) stretch (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .trigger (trig_reg),
        .hold    (hold)
    );

    // watchdog reset also clears prescaler, counter, guard and power state as a system reset would; the bus slave sees only sys_rst
    assign int_rst = sys_rst | hold;

    assign active = hw_opt | act_reg; // [RULE_03] [RULE_05]
    assign frozen = (pwr_reg == `WDG_ST_STOP); // [RULE_08] [RULE_09]
    assign tick   = ~frozen & (presc_reg == TICK_LAST); // [RULE_14]

    assign req    = avs_read | avs_write;
    assign hit    = (avs_address == `WDG_ADDR_COUNT_CONTROL);
    assign wr_hit = avs_write & ack_reg & hit & avs_byteenable[0];

    assign reg_view = cnt_to_reg(cnt_reg, active); // [RULE_12]

    // software write of zero to soft bit resets at once
    assign soft_clear = wr_hit &
                        ~avs_writedata[`WDG_BIT_SOFT_RESET]; // [RULE_11]

    // top stage falling 1 -> 0 on the decrement
    assign expire = active & tick & cnt_reg[6] &
                    (cnt_reg[5:0] == `WDG_CNT_ZERO) & ~wr_hit; // [RULE_02]

    assign guard_done = (guard_reg == GUARD_N); // [RULE_18]

    // prescaler: restarts on reload so the written period is exact
    always @(posedge clk_sys) begin
        if (int_rst) begin
            presc_reg <= 12'h000;
        end else if (wr_hit) begin
            presc_reg <= 12'h000;
        end else if (!frozen) begin
            if (presc_reg == TICK_LAST) begin
                presc_reg <= 12'h000;
            end else begin
                presc_reg <= presc_reg + 12'h001;
            end
        end
    end

    // counter and activation bit
    always @(posedge clk_sys) begin
        if (int_rst) begin
            cnt_reg <= `WDG_CNT_RESET; // [RULE_10]
            act_reg <= 1'b0; // [RULE_10]
        end else begin
            if (wr_hit) begin
                cnt_reg <= reg_to_cnt(avs_writedata[7:0]); // [RULE_20]
            end else if (tick) begin
                // inactive: wraps freely as a 7-bit timer
                cnt_reg <= cnt_reg - 7'h01; // [RULE_01] [RULE_13]
            end
            if (wr_hit && avs_writedata[`WDG_BIT_ACTIVATE]) begin
                act_reg <= 1'b1; // [RULE_04]
            end
        end
    end

    // an expiry inside the guard window waits for it to close
    always @(posedge clk_sys) begin
        if (int_rst) begin
            guard_reg    <= 5'h00;
            active_d_reg <= 1'b0;
            pending_reg  <= 1'b0;
            trig_reg     <= 1'b0;
        end else begin
            active_d_reg <= active;
            if (active && !active_d_reg) begin
                guard_reg <= 5'h00; // [RULE_18]
            end else if (active && instr_done && !guard_done) begin
                guard_reg <= guard_reg + 5'h01;
            end
            if (expire) begin
                pending_reg <= 1'b1;
            end
            // one-cycle pulse, else the stretcher restarts and runs long
            trig_reg <= ~trig_reg & (soft_clear |
                        ((expire | pending_reg) & guard_done)); // [RULE_01]
        end
    end

    // power state on a stop instruction
    always @* begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            `WDG_ST_RUN: begin
                if (stop_instr) begin
                    if (!active) begin
                        pwr_next = `WDG_ST_STOP; // [RULE_07]
                    end else if (ext_opt && nmi_level) begin
                        pwr_next = `WDG_ST_STOP; // [RULE_08]
                    end else begin
                        // oscillator must keep running
                        pwr_next = `WDG_ST_WAIT; // [RULE_06] [RULE_08]
                    end
                end
            end
            `WDG_ST_WAIT: begin
                if (wake_irq) begin
                    pwr_next = `WDG_ST_RUN;
                end
            end
            `WDG_ST_STOP: begin
                if (wake_irq) begin
                    pwr_next = `WDG_ST_RUN; // [RULE_09]
                end
            end
            default: begin
                pwr_next = `WDG_ST_RUN;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (int_rst) begin
            pwr_reg <= `WDG_ST_RUN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // bus slave: one wait cycle, then the answer
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (avs_read && !ack_reg) begin
                // unmapped addresses read as zero
                rdata_reg <= hit ? {24'h00_0000, reg_view} : 32'h0000_0000;
            end
        end
    end

    assign avs_waitrequest = req & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    assign stop_mode       = (pwr_reg == `WDG_ST_STOP);
    assign wait_mode       = (pwr_reg == `WDG_ST_WAIT);
    assign watchdog_active = active;
    assign wdg_reset       = hold; // [RULE_17]
    // open drain: only ever pulls the shared reset line low
    assign reset_pin_o     = 1'b0;
    assign reset_pin_oe    = hold; // [RULE_19]

endmodule

`default_nettype wire

// File: dv/watchdog_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module watchdog_core_sva (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // register bus
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // core events and option
    input wire logic        opt_ext_stop,
    input wire logic        stop_instr,
    input wire logic        wake_irq,
    // status and reset
    input wire logic        stop_mode,
    input wire logic        wait_mode,
    input wire logic        watchdog_active,
    input wire logic        wdg_reset,
    input wire logic        reset_pin_o,
    input wire logic        reset_pin_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // stretch length follows the bench's STAB_CYCLES of 8
    sequence held_reset;
        wdg_reset [*8] ##1 !wdg_reset;
    endsequence
    chk_one_wait:
        assert property ($rose(avs_read || avs_write) |-> one_wait)
        else $error("bad wait");
    chk_pin_follow:
        assert property (reset_pin_oe == wdg_reset && !reset_pin_o)
        else $error("pin drive");
    chk_reset_len:
        assert property ($rose(wdg_reset) |-> held_reset)
        else $error("reset length");
    chk_soft_reset:
        assert property (avs_write && !avs_waitrequest && !wdg_reset &&
            avs_address == 8'hD8 && !avs_writedata[1] |-> ##[1:3] wdg_reset)
        else $error("soft reset");
    chk_stop_idle:
        assert property (stop_instr && !watchdog_active && !stop_mode &&
            !wait_mode |=> stop_mode)
        else $error("stop idle");
    chk_stop_wait:
        assert property (stop_instr && watchdog_active && !opt_ext_stop &&
            !stop_mode && !wait_mode |=> wait_mode)
        else $error("stop wait");
    chk_wake_run:
        assert property (wake_irq && (stop_mode || wait_mode) |=>
            !stop_mode && !wait_mode)
        else $error("wake");
    chk_unmapped_zero:
        assert property (avs_read && !avs_waitrequest &&
            avs_address != 8'hD8 |-> avs_readdata == 32'h0)
        else $error("unmapped read");
endmodule
`default_nettype wire

// File: dv/core_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_bus_model (
    // clock
    input  wire logic        clk_sys,
    // avalon-mm master
    output var  logic [7:0]  avs_address = 8'h00,
    output var  logic        avs_read = 1'b0,
    output var  logic        avs_write = 1'b0,
    output var  logic [31:0] avs_writedata = 32'h0,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= w;
        avs_read      <= ~w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        // released lines carry junk, never the old request
        avs_address   <= ~a;
        avs_writedata <= {24'hFFFFFF, ~d};
        avs_write     <= 1'b0;
        avs_read      <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: dv/watchdog_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module watchdog_core_tb;
    logic        clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address, q;
    logic [31:0] avs_writedata, avs_readdata;
    logic        opt_hw_activation, opt_ext_stop, nmi_pin, ins_en;
    logic        stop_instr, wake_irq, stop_mode, wait_mode;
    logic        instr_done = 1'b0;
    logic        watchdog_active, wdg_reset, reset_pin_o, reset_pin_oe;
    int          bad_count, n_checks, i;
    watchdog_core #(.TICK_CYCLES(16), .GUARD_INSTR(3), .STAB_CYCLES(8))
    watchdog_core_inst (
        .clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'h1), .avs_readdata,
        .avs_waitrequest, .opt_hw_activation, .opt_ext_stop, .nmi_pin,
        .stop_instr, .wake_irq, .instr_done, .stop_mode, .wait_mode,
        .watchdog_active, .wdg_reset, .reset_pin_o, .reset_pin_oe);
    core_bus_model core_bus_model_inst (
        .clk_sys, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // one instruction every other cycle while enabled
    always @(posedge clk_sys)
        instr_done <= ins_en & ~instr_done;
    function automatic logic [7:0] enc(input logic [6:0] c, input logic a);
        enc = {c[0], c[1], c[2], c[3], c[4], c[5], c[6], a};
    endfunction
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        core_bus_model_inst.xfer(1'b1, 8'hD8, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        core_bus_model_inst.xfer(1'b0, a, 8'h00, q);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wait_for(input logic v, input int lim);
        for (i = 0; i < lim && wdg_reset !== v; i++)
            cyc(1);
    endtask
    task automatic reboot(input logic hw, input logic ext);
        sys_rst <= 1'b1;
        opt_hw_activation <= hw;
        opt_ext_stop <= ext;
        cyc(3);
        sys_rst <= 1'b0;
        cyc(3);
    endtask
    task automatic pulse(input logic wake);
        wake_irq <= wake;
        stop_instr <= ~wake;
        cyc(1);
        wake_irq <= 1'b0;
        stop_instr <= 1'b0;
        cyc(1);
    endtask
    task automatic t_boot;
        rd(8'hD8);
        check(q, 8'hFE);
        check(8'(watchdog_active), 8'h00);
        rd(8'h00);
        check(q, 8'h00);
        pulse(1'b0);
        check(8'(stop_mode), 8'h01);
        pulse(1'b1);
        check(8'(stop_mode), 8'h00);
    endtask
    task automatic t_timer;
        wr(enc(7'h40, 1'b0));
        // stop early if a reset shows, so a stray one is not missed
        wait_for(1'b1, 24);
        check(8'(wdg_reset), 8'h00);
        rd(8'hD8);
        check(q, enc(7'h3F, 1'b0));
        wr(enc(7'h3F, 1'b0));
        wait_for(1'b1, 10);
        check(8'(reset_pin_oe), 8'h01);
        wait_for(1'b0, 20);
    endtask
    task automatic t_expire;
        ins_en <= 1'b0;
        wr(enc(7'h7F, 1'b1));
        wr(enc(7'h7F, 1'b0));
        rd(8'hD8);
        check(8'({q[0], watchdog_active}), 8'h03);
        wr(enc(7'h40, 1'b1));
        wait_for(1'b1, 40);
        check(8'(wdg_reset), 8'h00);
        ins_en <= 1'b1;
        wait_for(1'b1, 12);
        check(8'(wdg_reset), 8'h01);
        wait_for(1'b0, 20);
        check(8'(watchdog_active), 8'h00);
        wr(enc(7'h41, 1'b1));
        wait_for(1'b1, 60);
        check(8'(i >= 32 && i <= 36), 8'h01);
        wait_for(1'b0, 20);
    endtask
    task automatic t_hw;
        reboot(1'b1, 1'b0);
        wr(enc(7'h7F, 1'b0));
        rd(8'hD8);
        check(q, 8'hFF);
        pulse(1'b0);
        check(8'({stop_mode, wait_mode}), 8'h01);
        pulse(1'b1);
        reboot(1'b1, 1'b1);
        pulse(1'b0);
        check(8'(stop_mode), 8'h01);
        cyc(40);
        pulse(1'b1);
        rd(8'hD8);
        check(q, 8'hFF);
        cyc(12);
        rd(8'hD8);
        check(q, enc(7'h7E, 1'b1));
        nmi_pin <= 1'b0;
        cyc(3);
        pulse(1'b0);
        check(8'({stop_mode, wait_mode}), 8'h01);
    endtask
    task automatic test_done;
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        opt_hw_activation = 1'b0;
        opt_ext_stop = 1'b0;
        nmi_pin = 1'b1;
        stop_instr = 1'b0;
        wake_irq = 1'b0;
        ins_en = 1'b1;
        reboot(1'b0, 1'b0);
        t_boot;
        t_timer;
        t_expire;
        t_hw;
        test_done;
    end
    initial begin
        cyc(5000);
        bad_count++;
        test_done;
    end
endmodule
bind watchdog_core watchdog_core_sva watchdog_core_sva_inst (
    .clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .opt_ext_stop,
    .stop_instr, .wake_irq, .stop_mode, .wait_mode, .watchdog_active,
    .wdg_reset, .reset_pin_o, .reset_pin_oe);
`default_nettype wire
